/* logic/redrv_defines.svh */
// Constants of the redriver equalization control block.
// Included by bare name; definitions only.
`ifndef REDRV_DEFINES_SVH
`define REDRV_DEFINES_SVH
`define CLK_MHZ         10
`define SWEEP_DONE_US   400
`define QUICK_DONE_US   60
`define LANE_X1_US      100
`define SWEEP_STEPS_MAX 16
`define EQ_MAX          4'hF
`define EQ_ZERO         4'h0
`define SWEEP_UPPER_DEF 4'h8
`define QUICK_SHORT_EQ  4'h2
`define QUICK_LONG_EQ   4'h9
`endif

/* logic/redrv_pkg.sv */
// Types shared by the redriver equalization control block.
// Assumes nothing of its surroundings.
package redrv_pkg;
  // Four-level strap code, ordered low, resistor-to-ground, float, high
  typedef enum logic [1:0] {LVL_LOW, LVL_RGND, LVL_FLOAT, LVL_HIGH} strap_lvl_t;
  typedef struct packed {
    strap_lvl_t hi;
    strap_lvl_t lo;
  } strap_pair_t;
  typedef struct packed {
    strap_pair_t conn_eq;
    strap_pair_t host_eq;
    strap_lvl_t  conn_mode;
  } strap_set_t;
  typedef enum logic [1:0] {
    fixed_equalization, quick_adaptive_equalization, sweep_adaptive_equalization
  } eq_mode_t;
  typedef struct packed {
    logic       limited;
    logic [1:0] preshoot;
    logic [1:0] deemph;
  } host_tx_cfg_t;
  typedef enum logic [1:0] {ST_IDLE, ST_QUICK, ST_SWEEP} adapt_st_t;
endpackage

/* logic/usb_redriver_eq_control.sv */
// Equalization, redriver mode, strap latch and lane detect control.
// Assumes strap pins arrive as two-bit level codes from the pad comparators,
// activity and detect flags from analog, eye metric on mclk_i.
//
// Summary of operation
// - Detect x2 or x1 operation; power down the unused lane in x1.
// - Up to 16 equalization settings, from straps or configuration registers.
// - Connector-facing receivers support fixed, quick adaptive and sweep adaptive modes.
// - Host-facing receivers use fixed equalization only, never adaptation.
// - Connector receiver mode comes from strap or configuration registers.
// - Host-to-connector path always runs as linear redriver.
// - Connector-to-host path resets linear; limited only when register enables it.
// - Limited mode gives four pre-shoot and four de-emphasis levels.
// - Sample all four-level straps once just after enable rises.
// - After sampling, disconnect strap pull-up and pull-down resistors.
// - Each strap decodes to low, resistor, float or high, a base-four digit.
// - Each receiver group takes its setting from its own strap pair.
// - Fixed mode applies one constant setting regardless of the channel.
// - Quick adaptive classifies short or long and applies one of two settings.
// - Sweep adaptive searches anew on every insertion at the receptacle.
// - Sweep runs upward from zero to a programmable limit, default eight.
// - Add offset to sweep result when sign is 0, subtract when 1.
// - Offset result is clamped to never exceed fifteen.
// - Sweep finishes within 400 us; quick decision within 60 us.
`timescale 1ns/10ps
`include "redrv_defines.svh"
module usb_redriver_eq_control #(
  parameter int LANE_X1_CYC = `LANE_X1_US * `CLK_MHZ
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    en_i,
  input  wire redrv_pkg::strap_set_t   strap_i,
  input  wire logic                    cfg_reg_sel_i,
  input  wire redrv_pkg::eq_mode_t     reg_conn_mode_i,
  input  wire logic [3:0]              reg_conn_eq_lane1_i,
  input  wire logic [3:0]              reg_conn_eq_lane2_i,
  input  wire logic [3:0]              reg_host_eq_lane1_i,
  input  wire logic [3:0]              reg_host_eq_lane2_i,
  input  wire redrv_pkg::host_tx_cfg_t reg_host_tx_i,
  input  wire logic [3:0]              sweep_upper_limit_i,
  input  wire logic [3:0]              eq_offset_value_i,
  input  wire logic                    eq_offset_sign_i,
  input  wire logic                    conn_insert_i,
  input  wire logic                    chan_class_valid_i,
  input  wire logic                    chan_long_i,
  input  wire logic [7:0]              eye_metric_i,
  input  wire logic                    lane1_active_i,
  input  wire logic                    lane2_active_i,
  output logic [3:0]                   conn_eq_lane1_o,
  output logic [3:0]                   conn_eq_lane2_o,
  output logic [3:0]                   host_eq_lane1_o,
  output logic [3:0]                   host_eq_lane2_o,
  output redrv_pkg::host_tx_cfg_t      host_tx_cfg_o,
  output logic                         conn_tx_linear_o,
  output logic                         strap_bias_en_o,
  output logic                         adapt_busy_o,
  output logic                         lane2_pd_o
);
  localparam int SWEEP_CYC = `SWEEP_DONE_US * `CLK_MHZ;
  localparam int DWELL_CYC = SWEEP_CYC / `SWEEP_STEPS_MAX;
  localparam int QUICK_CYC = `QUICK_DONE_US * `CLK_MHZ;
  localparam int SYNC_W    = $bits(redrv_pkg::strap_set_t) + 4;

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0]            rst_sync_r;
  logic                  rst_n;
  logic [SYNC_W-1:0]     sync1_r;
  logic [SYNC_W-1:0]     sync2_r;
  redrv_pkg::strap_set_t strap_s;
  logic                  en_s;
  logic                  insert_s;
  logic                  lane1_s;
  logic                  lane2_s;

  // Release reset through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) rst_sync_r <= 2'h0;
    else          rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Two flops on every pin-level input
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {strap_i, en_i, conn_insert_i, lane1_active_i, lane2_active_i};
      sync2_r <= sync1_r;
    end
  end
  assign {strap_s, en_s, insert_s, lane1_s, lane2_s} = sync2_r;

  // ----------------------------------------------------------------
  // Strap latch on enable rise
  // ----------------------------------------------------------------
  logic                  en_d_r;
  logic                  en_rise;
  logic                  insert_d_r;
  logic                  insert_rise;
  redrv_pkg::strap_set_t strap_r;

  assign en_rise     = en_s & ~en_d_r;
  assign insert_rise = insert_s & ~insert_d_r;

  // Capture once per enable rise, hold while enabled
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_d_r          <= 1'b0;
      insert_d_r      <= 1'b0;
      strap_r         <= '0;
      strap_bias_en_o <= 1'b1;
    end else begin
      en_d_r     <= en_s;
      insert_d_r <= insert_s;
      if (en_rise) strap_r <= strap_s;
      if (en_rise) strap_bias_en_o <= 1'b0;
      else if (!en_s) strap_bias_en_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Source selection: straps or configuration registers
  // ----------------------------------------------------------------
  logic [3:0]          strap_conn_eq;
  logic [3:0]          strap_host_eq;
  redrv_pkg::eq_mode_t strap_mode;
  redrv_pkg::eq_mode_t conn_mode;
  logic [3:0]          fix_l1;
  logic [3:0]          fix_l2;
  logic [3:0]          host_l1;
  logic [3:0]          host_l2;

  // Strap pair reads as a two-digit base-four number
  assign strap_conn_eq = {strap_r.conn_eq.hi, strap_r.conn_eq.lo};
  assign strap_host_eq = {strap_r.host_eq.hi, strap_r.host_eq.lo};
  assign strap_mode =
    (strap_r.conn_mode == redrv_pkg::LVL_RGND)  ? redrv_pkg::quick_adaptive_equalization :
    (strap_r.conn_mode == redrv_pkg::LVL_FLOAT) ? redrv_pkg::sweep_adaptive_equalization :
                                                  redrv_pkg::fixed_equalization;
  assign conn_mode = cfg_reg_sel_i ? reg_conn_mode_i : strap_mode;
  assign fix_l1    = cfg_reg_sel_i ? reg_conn_eq_lane1_i : strap_conn_eq;
  assign fix_l2    = cfg_reg_sel_i ? reg_conn_eq_lane2_i : strap_conn_eq;
  assign host_l1   = cfg_reg_sel_i ? reg_host_eq_lane1_i : strap_host_eq;
  assign host_l2   = cfg_reg_sel_i ? reg_host_eq_lane2_i : strap_host_eq;

  // ----------------------------------------------------------------
  // Adaptation engine
  // ----------------------------------------------------------------
  redrv_pkg::adapt_st_t st_r;
  logic [11:0]          timer_r;
  logic [3:0]           step_r;
  logic [3:0]           best_eq_r;
  logic [7:0]           best_metric_r;
  logic [3:0]           adapt_eq_r;
  logic                 adapt_start;
  logic                 dwell_end;
  logic                 take_step;
  logic [3:0]           final_eq;
  logic                 sweep_fin;
  logic                 quick_fin;
  logic [4:0]           off_sum;
  logic [3:0]           off_eq;

  assign adapt_start = insert_rise & en_s & (conn_mode != redrv_pkg::fixed_equalization);
  assign dwell_end   = (timer_r == 12'(DWELL_CYC - 1));
  assign take_step   = (step_r == `EQ_ZERO) | (eye_metric_i > best_metric_r);
  assign final_eq    = take_step ? step_r : best_eq_r;
  assign sweep_fin   = (st_r == redrv_pkg::ST_SWEEP) & dwell_end & (step_r >= sweep_upper_limit_i);
  assign quick_fin   = (st_r == redrv_pkg::ST_QUICK) &
                       (chan_class_valid_i | (timer_r == 12'(QUICK_CYC - 1)));
  // Offset with floor at zero and ceiling at the top setting
  assign off_sum = {1'b0, final_eq} + {1'b0, eq_offset_value_i};
  assign off_eq  = eq_offset_sign_i ?
                   ((eq_offset_value_i > final_eq) ? `EQ_ZERO : final_eq - eq_offset_value_i) :
                   (off_sum[4] ? `EQ_MAX : off_sum[3:0]);

  // Search sequencer
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= redrv_pkg::ST_IDLE;
      timer_r       <= '0;
      step_r        <= `EQ_ZERO;
      best_eq_r     <= `EQ_ZERO;
      best_metric_r <= '0;
      adapt_eq_r    <= `EQ_ZERO;
    end else begin
      unique case (st_r)
        redrv_pkg::ST_IDLE: begin
          timer_r <= '0;
          step_r  <= `EQ_ZERO;
          if (adapt_start) begin
            st_r <= (conn_mode == redrv_pkg::quick_adaptive_equalization) ?
                    redrv_pkg::ST_QUICK : redrv_pkg::ST_SWEEP;
          end
        end
        redrv_pkg::ST_QUICK: begin
          timer_r <= timer_r + 12'h001;
          if (quick_fin) begin
            adapt_eq_r <= (chan_class_valid_i & !chan_long_i) ? `QUICK_SHORT_EQ : `QUICK_LONG_EQ;
            st_r       <= redrv_pkg::ST_IDLE;
          end
        end
        redrv_pkg::ST_SWEEP: begin
          timer_r <= dwell_end ? 12'h000 : timer_r + 12'h001;
          if (dwell_end) begin
            best_eq_r     <= final_eq;
            best_metric_r <= take_step ? eye_metric_i : best_metric_r;
            step_r        <= step_r + 4'h1;
          end
          if (sweep_fin) begin
            adapt_eq_r <= off_eq;
            st_r       <= redrv_pkg::ST_IDLE;
          end
        end
        default: st_r <= redrv_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Applied settings
  // ----------------------------------------------------------------
  logic       adaptive;
  logic [3:0] conn_l1;
  logic [3:0] conn_l2;

  assign adaptive = conn_mode != redrv_pkg::fixed_equalization;
  // Sweep drives each trial setting out so the eye metric measures it
  assign conn_l1  = (adaptive & (st_r == redrv_pkg::ST_SWEEP)) ? step_r :
                    adaptive ? adapt_eq_r : fix_l1;
  assign conn_l2  = (adaptive & (st_r == redrv_pkg::ST_SWEEP)) ? step_r :
                    adaptive ? adapt_eq_r : fix_l2;

  // Output registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      conn_eq_lane1_o  <= `EQ_ZERO;
      conn_eq_lane2_o  <= `EQ_ZERO;
      host_eq_lane1_o  <= `EQ_ZERO;
      host_eq_lane2_o  <= `EQ_ZERO;
      host_tx_cfg_o    <= '0;
      conn_tx_linear_o <= 1'b1;
      adapt_busy_o     <= 1'b0;
    end else begin
      conn_eq_lane1_o  <= conn_l1;
      conn_eq_lane2_o  <= conn_l2;
      host_eq_lane1_o  <= host_l1;
      host_eq_lane2_o  <= host_l2;
      host_tx_cfg_o    <= (cfg_reg_sel_i & reg_host_tx_i.limited) ? reg_host_tx_i : '0;
      conn_tx_linear_o <= 1'b1;
      adapt_busy_o     <= st_r != redrv_pkg::ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Lane count detection
  // ----------------------------------------------------------------
  logic [15:0] x1_cnt_r;

  // Lane two idle long while lane one runs means x1
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      x1_cnt_r   <= '0;
      lane2_pd_o <= 1'b0;
    end else if (lane2_s || !en_s || !lane1_s) begin
      x1_cnt_r   <= '0;
      lane2_pd_o <= 1'b0;
    end else if (x1_cnt_r >= 16'(LANE_X1_CYC - 1)) begin
      lane2_pd_o <= 1'b1;
    end else begin
      x1_cnt_r <= x1_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [11:0] busy_cyc_r;

  // Cycles spent in one adaptation
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) busy_cyc_r <= '0;
    else        busy_cyc_r <= (st_r == redrv_pkg::ST_IDLE) ? 12'h000 : busy_cyc_r + 12'h001;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  a_strap_capture: assert property (en_rise |=> strap_r == $past(strap_s))
    else $error("straps not captured on enable rise");
  a_strap_hold: assert property (en_s && en_d_r |=> $stable(strap_r))
    else $error("straps changed while enabled");
  a_bias_off: assert property (en_rise |=> !strap_bias_en_o ##1 (!strap_bias_en_o || !en_s))
    else $error("strap bias still connected after sampling");
  a_fixed_strap: assert property (!cfg_reg_sel_i && !adaptive |=> conn_eq_lane1_o == $past(strap_conn_eq))
    else $error("fixed strap setting not applied");
  a_host_strap: assert property (!cfg_reg_sel_i |=> host_eq_lane2_o == $past(strap_host_eq))
    else $error("host receiver not on its strap pair");
  a_limited_gate: assert property (!cfg_reg_sel_i |=> !host_tx_cfg_o.limited)
    else $error("limited mode without register enable");
  a_conn_linear: assert property (conn_tx_linear_o)
    else $error("host-to-connector path left linear mode");
  a_sweep_from_zero: assert property (st_r == redrv_pkg::ST_IDLE && adapt_start |=> step_r == `EQ_ZERO)
    else $error("sweep did not start at setting zero");
  a_sweep_trial: assert property (adaptive && st_r == redrv_pkg::ST_SWEEP
    |=> conn_eq_lane1_o == $past(step_r))
    else $error("swept setting not applied to receivers");
  a_offset_add: assert property (sweep_fin && !eq_offset_sign_i && !off_sum[4]
    |=> adapt_eq_r == $past(final_eq) + $past(eq_offset_value_i))
    else $error("offset not added");
  a_offset_clamp: assert property (sweep_fin && !eq_offset_sign_i && off_sum[4] |=> adapt_eq_r == `EQ_MAX)
    else $error("offset sum not clamped");
  a_sweep_time: assert property (st_r != redrv_pkg::ST_IDLE |-> busy_cyc_r < 12'(SWEEP_CYC))
    else $error("sweep ran past its time limit");
  a_quick_time: assert property (st_r == redrv_pkg::ST_QUICK |-> busy_cyc_r < 12'(QUICK_CYC))
    else $error("quick decision ran past its time limit");
  a_lane_wake: assert property (lane2_s |=> !lane2_pd_o)
    else $error("lane two powered down while active");

  c_sweep_done: cover property (sweep_fin);
  c_quick_done: cover property (quick_fin && chan_long_i);
  c_lane_x1: cover property (!lane2_pd_o ##1 lane2_pd_o);
  c_strap_latch: cover property (en_rise);
endmodule

/* bench/redrv_analog_model.sv */
// Behavioural analog front end that the equalization control steers.
// Assumes the adaptation busy flag from the control block and mclk_i.
`timescale 1ns/10ps
module redrv_analog_model (
  input  wire logic       mclk_i,
  input  wire logic       busy_i,
  input  wire logic       long_sel_i,
  input  wire logic       ramp_i,
  output logic [7:0]      eye_metric_o,
  output logic            class_valid_o,
  output logic            chan_long_o
);
  logic [11:0] busy_cnt_r;

  // ----------------------------------------
  // Channel response while adapting
  // ----------------------------------------
  // Cycles since adaptation started
  always_ff @(posedge mclk_i) begin
    busy_cnt_r <= busy_i ? busy_cnt_r + 12'h001 : 12'h000;
  end
  // Classifier answers late; class line is inverted while not valid
  assign class_valid_o = busy_i && (busy_cnt_r >= 12'h014);
  assign chan_long_o   = class_valid_o ? long_sel_i : ~long_sel_i;
  // Eye improves with each sweep step, or stays flat
  assign eye_metric_o  = ramp_i ? busy_cnt_r[11:4] : 8'h40;
endmodule

/* bench/usb_redriver_eq_control_tb.sv */
// Self-checking bench for the redriver equalization control.
// Assumes the analog model in bench/ and the design files under logic/.
`timescale 1ns/10ps
module usb_redriver_eq_control_tb;
  logic                    mclk = 1'b0, rst_b = 1'b0, en = 1'b0, sel = 1'b0, ins = 1'b0;
  logic                    l1 = 1'b1, l2 = 1'b1, long_sel = 1'b0, ramp = 1'b0, o_sign = 1'b0;
  logic [3:0]              rc1 = 4'h0, rc2 = 4'h0, rh1 = 4'h0, rh2 = 4'h0;
  logic [3:0]              upper = 4'h8, o_val = 4'h0;
  redrv_pkg::strap_set_t   strap = '0;
  redrv_pkg::eq_mode_t     mode = redrv_pkg::fixed_equalization;
  redrv_pkg::host_tx_cfg_t reg_tx = '0;
  redrv_pkg::host_tx_cfg_t tx_cfg;
  logic [3:0]              ce1, ce2, he1, he2;
  logic [7:0]              eye;
  logic                    cls_v, cls_l, linear, bias, busy, pd2;
  int                      n_mismatch = 0;
  int                      checks_done = 0;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  usb_redriver_eq_control #(.LANE_X1_CYC(8)) i_dut (
    .mclk_i(mclk), .rst_b_i(rst_b), .en_i(en), .strap_i(strap), .cfg_reg_sel_i(sel),
    .reg_conn_mode_i(mode), .reg_conn_eq_lane1_i(rc1), .reg_conn_eq_lane2_i(rc2),
    .reg_host_eq_lane1_i(rh1), .reg_host_eq_lane2_i(rh2), .reg_host_tx_i(reg_tx),
    .sweep_upper_limit_i(upper), .eq_offset_value_i(o_val), .eq_offset_sign_i(o_sign),
    .conn_insert_i(ins), .chan_class_valid_i(cls_v), .chan_long_i(cls_l),
    .eye_metric_i(eye), .lane1_active_i(l1), .lane2_active_i(l2),
    .conn_eq_lane1_o(ce1), .conn_eq_lane2_o(ce2), .host_eq_lane1_o(he1),
    .host_eq_lane2_o(he2), .host_tx_cfg_o(tx_cfg), .conn_tx_linear_o(linear),
    .strap_bias_en_o(bias), .adapt_busy_o(busy), .lane2_pd_o(pd2)
  );

  redrv_analog_model i_afe (
    .mclk_i(mclk), .busy_i(busy), .long_sel_i(long_sel), .ramp_i(ramp),
    .eye_metric_o(eye), .class_valid_o(cls_v), .chan_long_o(cls_l)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and stop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Bounded wait: 0 busy high, 1 busy low, 2 lane two down
  task automatic wt(input int what, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge mclk);
      if ((what == 0 && busy === 1'b1) || (what == 1 && busy === 1'b0) ||
          (what == 2 && pd2 === 1'b1)) break;
    end
    if (i == lim) begin
      n_mismatch++;
      $display("MISMATCH t=%0t wait ran out", $time);
      end_sim;
    end
  endtask

  // Insertion, then wait for the adapted setting on both lanes
  task automatic adapt(input logic [3:0] exp, input int lim);
    ins <= 1'b1;
    wt(0, 20);
    wt(1, lim);
    cyc(4);
    ins <= 1'b0;
    chk(ce1, exp);
    chk(ce2, exp);
    cyc(4);
  endtask

  // Enable cycle with new straps, then disturb them while enabled
  // Expected connector setting is the strap pair in fixed mode, else the adapted value
  task automatic strap_run(input logic [3:0] c, input logic [3:0] h, input logic [1:0] m,
                           input logic [3:0] ec);
    en <= 1'b0;
    cyc(6);
    chk(bias, 1'b1);
    strap <= {c, h, m};
    cyc(2);
    en <= 1'b1;
    cyc(8);
    chk(bias, 1'b0);
    chk(ce1, ec);
    chk(ce2, ec);
    chk(he1, h);
    chk(he2, h);
    strap <= ~strap;
    cyc(8);
    chk(ce1, ec);
    chk(he2, h);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(20);
    rst_b <= 1'b1;
    cyc(5);
    chk(linear, 1'b1);
    chk(tx_cfg, 5'h00);
    chk(pd2, 1'b0);
    $display("test reset done");
    // Every strap level in both digits
    for (int k = 0; k < 4; k++)
      strap_run(4'(k * 5), 4'(15 - k * 5), (k == 2) ? 2'h3 : 2'h0, 4'(k * 5));
    ins <= 1'b1;
    cyc(10);
    chk(busy, 1'b0);
    chk(ce1, 4'hF);
    ins <= 1'b0;
    cyc(4);
    // Resistor level on mode strap picks quick adaptation
    strap_run(4'h7, 4'h1, 2'h1, 4'h0);
    adapt(4'h2, 600);
    chk(he1, 4'h1);
    // Float level on mode strap picks sweep adaptation; flat eye keeps setting zero
    strap_run(4'h6, 4'h4, 2'h2, 4'h2);
    adapt(4'h0, 4000);
    $display("test strap done");
    sel <= 1'b1;
    rc1 <= 4'h3;
    rc2 <= 4'hC;
    rh1 <= 4'h6;
    rh2 <= 4'hA;
    mode <= redrv_pkg::fixed_equalization;
    reg_tx <= 5'h0F;
    cyc(6);
    chk(ce1, 4'h3);
    chk(ce2, 4'hC);
    chk(he1, 4'h6);
    chk(he2, 4'hA);
    chk(tx_cfg, 5'h00);
    // All pre-shoot and de-emphasis levels
    for (int k = 0; k < 4; k++) begin
      reg_tx <= {1'b1, 2'(k), 2'(3 - k)};
      cyc(4);
      chk(tx_cfg, {1'b1, 2'(k), 2'(3 - k)});
      chk(linear, 1'b1);
    end
    $display("test register done");
    mode <= redrv_pkg::quick_adaptive_equalization;
    long_sel <= 1'b1;
    adapt(4'h9, 600);
    long_sel <= 1'b0;
    adapt(4'h2, 600);
    chk(he1, 4'h6);
    mode <= redrv_pkg::sweep_adaptive_equalization;
    ramp <= 1'b1;
    upper <= 4'h4;
    o_val <= 4'h2;
    o_sign <= 1'b1;
    adapt(4'h2, 4000);
    upper <= 4'h8;
    o_val <= 4'h9;
    o_sign <= 1'b0;
    adapt(4'hF, 4000);
    ramp <= 1'b0;
    upper <= 4'h5;
    o_val <= 4'h5;
    adapt(4'h5, 4000);
    chk(he2, 4'hA);
    $display("test adapt done");
    l2 <= 1'b0;
    wt(2, 40);
    chk(pd2, 1'b1);
    l2 <= 1'b1;
    cyc(6);
    chk(pd2, 1'b0);
    // Both lanes idle is no x1 link
    l1 <= 1'b0;
    l2 <= 1'b0;
    cyc(20);
    chk(pd2, 1'b0);
    $display("test lane done");
    end_sim;
  end
endmodule
